/* File: rtl/barrel_shift_unit.sv */
`include "dspu_defs.svh"

module barrel_shift_unit
	import dspu_pkg::*;
#(
	parameter int WIDTH = `REG_W
)
(
	// Operand and control
	input  wire logic [WIDTH-1:0]      operand,
	input  wire logic [`SHAMT_W-1:0]   amount,
	input  wire dspu_pkg::shift_mode_e mode,
	// Result
	output logic      [WIDTH-1:0]      result
);

	always_comb
	begin
		unique case (mode)
			SHIFT_LEFT:        result = operand << amount;                 // RULE_08
			SHIFT_RIGHT_ARITH: result = $signed(operand) >>> amount;      // RULE_09
			SHIFT_RIGHT_LOGIC: result = operand >> amount;                // RULE_10
			default:           result = operand;
		endcase
	end

endmodule

/* File: rtl/dsp_operation_unit.sv */
`include "dspu_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01: Instructions flow through three pipeline stages and one retires every clock.
// RULE_02: Eight 40-bit general registers feed the units and take results and loads.
// RULE_03: Each register splits into low 15:0, high 31:16 and extension 39:32 parts.
// RULE_04: The parts serve alone or combined into a wider operand, as the operation picks.
// RULE_05: The multiply-accumulator multiplies two 16-bit values and adds or subtracts to 40 bits.
// RULE_06: The addend may be shifted arithmetically right by 1 or 16 before accumulation.
// RULE_07: The ALU takes one or two 40-bit operands and produces a 40-bit result.
// RULE_08: The barrel shifter moves a 40-bit operand left or right by any count in one step.
// RULE_09: An arithmetic right shift fills vacated upper bits with the sign bit.
// RULE_10: A logical right shift fills vacated upper bits with zeros from the top.
// RULE_11: Multiplier inputs are signed and the product is sign-extended to 40 bits.
//////////////////////////////////////////////////////////////////////////////

module dsp_operation_unit
	import dspu_pkg::*;
(
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// Instruction from the sequencer, load data included
	input  wire dspu_pkg::instr_s   instr,
	// Result retiring into the register file
	output dspu_pkg::wb_s           retire,
	// Store path to data memory
	output logic                    store_valid,
	output logic [`HALF_W-1:0]      store_data,
	// Condition flags of the last arithmetic result
	output dspu_pkg::flags_s        flags
);

	import dspu_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// State

	logic [`REG_W-1:0]   general_registers_ff [`REG_CNT];
	logic [`REG_W-1:0]   nxt_general_registers [`REG_CNT];
	instr_s              decode_ff;
	instr_s              nxt_decode;
	wb_s                 wb_ff;
	wb_s                 nxt_wb;
	logic                store_valid_ff;
	logic                nxt_store_valid;
	logic [`HALF_W-1:0]  store_data_ff;
	logic [`HALF_W-1:0]  nxt_store_data;
	flags_s              flags_ff;
	flags_s              nxt_flags;

	//////////////////////////////////////////////////////////////////////////
	// Part helpers

	// Value of one part, sign-extended to the full width
	function automatic logic [`REG_W-1:0] part_operand(
		input logic [`REG_W-1:0] value,
		input part_e             part
	);
		logic [`REG_W-1:0] res;
		res = value;
		unique case (part)
			PART_LOW:
				res = {{(`REG_W-`HALF_W){value[`LOW_MSB]}},
					value[`LOW_MSB:`LOW_LSB]};                                  // RULE_04
			PART_HIGH:
				res = {{(`REG_W-`HALF_W){value[`HIGH_MSB]}},
					value[`HIGH_MSB:`HIGH_LSB]};                                // RULE_04
			PART_EXT:
				res = {{(`REG_W-`EXT_W){value[`EXT_MSB]}},
					value[`EXT_MSB:`EXT_LSB]};                                  // RULE_04
			default:
				res = value;
		endcase
		return res;
	endfunction

	// Sixteen-bit view of a part; a whole register gives its high part
	function automatic logic [`HALF_W-1:0] part_half(
		input logic [`REG_W-1:0] value,
		input part_e             part
	);
		logic [`REG_W-1:0] ext;
		ext = part_operand(value, part);
		if (part == PART_WHOLE)
			return value[`HIGH_MSB:`HIGH_LSB];
		return ext[`HALF_W-1:0];
	endfunction

	// Write a result into one part, leaving the other parts untouched
	function automatic logic [`REG_W-1:0] merge_part(
		input logic [`REG_W-1:0] old,
		input part_e             part,
		input logic [`REG_W-1:0] value
	);
		logic [`REG_W-1:0] res;
		res = old;
		unique case (part)
			PART_LOW:  res[`LOW_MSB:`LOW_LSB] = value[`HALF_W-1:0];            // RULE_03
			PART_HIGH: res[`HIGH_MSB:`HIGH_LSB] = value[`HALF_W-1:0];          // RULE_03
			PART_EXT:  res[`EXT_MSB:`EXT_LSB] = value[`EXT_W-1:0];             // RULE_03
			default:   res = value;                                            // RULE_03
		endcase
		return res;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Operand fetch with bypass from the write-back stage

	logic [`REG_W-1:0] wb_merged;
	logic [`REG_W-1:0] opnd_a_reg;
	logic [`REG_W-1:0] opnd_b_reg;
	logic [`REG_W-1:0] opnd_a;
	logic [`REG_W-1:0] opnd_b;

	always_comb
	begin
		wb_merged = merge_part(general_registers_ff[wb_ff.dst], wb_ff.part, wb_ff.value);
		// Bypass keeps back-to-back dependent instructions at one per cycle
		if (wb_ff.valid && wb_ff.dst == decode_ff.src_a)
			opnd_a_reg = wb_merged;                                              // RULE_01
		else
			opnd_a_reg = general_registers_ff[decode_ff.src_a];                  // RULE_02
		if (wb_ff.valid && wb_ff.dst == decode_ff.src_b)
			opnd_b_reg = wb_merged;                                              // RULE_01
		else
			opnd_b_reg = general_registers_ff[decode_ff.src_b];                  // RULE_02
		opnd_a = part_operand(opnd_a_reg, decode_ff.src_a_part);
		opnd_b = part_operand(opnd_b_reg, decode_ff.src_b_part);
	end

	//////////////////////////////////////////////////////////////////////////
	// Execution units

	logic [`REG_W-1:0] mac_result;
	logic [`REG_W-1:0] mac_addend;
	logic              mac_subtract;
	logic [`REG_W-1:0] shift_result;
	shift_mode_e       shift_mode;

	always_comb
	begin
		mac_addend = (decode_ff.op == OP_MUL) ? '0 : opnd_a;
		mac_subtract = (decode_ff.op == OP_MAC_SUB);
		unique case (decode_ff.op)
			OP_SHR_ARITH: shift_mode = SHIFT_RIGHT_ARITH;
			OP_SHR_LOGIC: shift_mode = SHIFT_RIGHT_LOGIC;
			default:      shift_mode = SHIFT_LEFT;
		endcase
	end

	// Multipliers are the sixteen-bit views of both sources
	multiply_accumulator u_mac
	(
		.mul_a    (part_half(opnd_a_reg, decode_ff.src_a_part)),
		.mul_b    (part_half(opnd_b_reg, decode_ff.src_b_part)),
		.addend   (mac_addend),
		.preshift (decode_ff.preshift),
		.subtract (mac_subtract),
		.result   (mac_result)
	);

	barrel_shift_unit #(.WIDTH(`REG_W)) u_barrel_shift_unit
	(
		.operand (opnd_a),
		.amount  (decode_ff.shamt),
		.mode    (shift_mode),
		.result  (shift_result)
	);

	//////////////////////////////////////////////////////////////////////////
	// Arithmetic/logic unit

	logic [`REG_W-1:0] alu_result;
	logic              alu_writes;
	logic              alu_overflow;
	logic              sets_flags;

	always_comb
	begin
		alu_result = '0;
		alu_writes = 1'b1;
		alu_overflow = 1'b0;
		sets_flags = 1'b1;
		unique case (decode_ff.op)
			OP_NOP:
			begin
				alu_writes = 1'b0;
				sets_flags = 1'b0;
			end
			OP_STORE:
			begin
				alu_writes = 1'b0;
				sets_flags = 1'b0;
			end
			OP_LOAD:
			begin
				alu_result = {{(`REG_W-`HALF_W){decode_ff.load_data[`HALF_W-1]}},
					decode_ff.load_data};                                       // RULE_02
				sets_flags = 1'b0;
			end
			OP_MOVE:  alu_result = opnd_a;                                      // RULE_07
			OP_CLR:   alu_result = '0;                                          // RULE_07
			OP_ADD:
			begin
				alu_result = opnd_a + opnd_b;                                   // RULE_07
				alu_overflow = (opnd_a[`REG_W-1] == opnd_b[`REG_W-1])
					&& (alu_result[`REG_W-1] != opnd_a[`REG_W-1]);
			end
			OP_SUB:
			begin
				alu_result = opnd_a - opnd_b;                                   // RULE_07
				alu_overflow = (opnd_a[`REG_W-1] != opnd_b[`REG_W-1])
					&& (alu_result[`REG_W-1] != opnd_a[`REG_W-1]);
			end
			OP_AND:   alu_result = opnd_a & opnd_b;                             // RULE_07
			OP_OR:    alu_result = opnd_a | opnd_b;                             // RULE_07
			OP_XOR:   alu_result = opnd_a ^ opnd_b;                             // RULE_07
			OP_NOT:   alu_result = ~opnd_a;                                     // RULE_07
			OP_NEG:
			begin
				alu_result = '0 - opnd_a;                                       // RULE_07
				alu_overflow = opnd_a[`REG_W-1] && alu_result[`REG_W-1];
			end
			OP_ABS:
			begin
				alu_result = opnd_a[`REG_W-1] ? ('0 - opnd_a) : opnd_a;         // RULE_07
				alu_overflow = alu_result[`REG_W-1];
			end
			OP_INC:   alu_result = opnd_a + `REG_W'h1;                          // RULE_07
			OP_DEC:   alu_result = opnd_a - `REG_W'h1;                          // RULE_07
			OP_MAC_ADD, OP_MAC_SUB, OP_MUL:
				alu_result = mac_result;                                        // RULE_05
			OP_SHL, OP_SHR_ARITH, OP_SHR_LOGIC:
				alu_result = shift_result;                                      // RULE_08
			default:
			begin
				alu_writes = 1'b0;
				sets_flags = 1'b0;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Pipeline: decode, execute, write back

	always_comb
	begin
		nxt_decode = instr;                                                     // RULE_01
		nxt_wb.valid = decode_ff.valid && alu_writes;                           // RULE_01
		nxt_wb.dst = decode_ff.dst;
		nxt_wb.part = decode_ff.dst_part;
		nxt_wb.value = alu_result;
		nxt_store_valid = decode_ff.valid && decode_ff.op == OP_STORE;          // RULE_02
		nxt_store_data = part_half(opnd_a_reg, decode_ff.src_a_part);           // RULE_04
		if (decode_ff.src_a_part == PART_WHOLE)
			nxt_store_data = opnd_a_reg[`LOW_MSB:`LOW_LSB];
		nxt_flags = flags_ff;
		if (decode_ff.valid && sets_flags)
		begin
			nxt_flags.zero = (alu_result == '0);
			nxt_flags.negative = alu_result[`REG_W-1];
			nxt_flags.overflow = alu_overflow;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			decode_ff <= '0;
			wb_ff <= '0;
			store_valid_ff <= 1'b0;
			store_data_ff <= '0;
			flags_ff <= '0;
		end
		else
		begin
			decode_ff <= nxt_decode;
			wb_ff <= nxt_wb;
			store_valid_ff <= nxt_store_valid;
			store_data_ff <= nxt_store_data;
			flags_ff <= nxt_flags;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// General register file

	always_comb
	begin
		for (int i = 0; i < `REG_CNT; i++)
			nxt_general_registers[i] = general_registers_ff[i];
		if (wb_ff.valid)
			nxt_general_registers[wb_ff.dst] = wb_merged;                       // RULE_02
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			for (int i = 0; i < `REG_CNT; i++)
				general_registers_ff[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < `REG_CNT; i++)
				general_registers_ff[i] <= nxt_general_registers[i];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs

	assign retire = wb_ff;
	assign store_valid = store_valid_ff;
	assign store_data = store_data_ff;
	assign flags = flags_ff;

endmodule

/* File: rtl/dspu_defs.svh */
`ifndef DSPU_DEFS_SVH
`define DSPU_DEFS_SVH

// Register geometry
`define REG_W        40
`define REG_CNT      8
`define SEL_W        3
`define HALF_W       16
`define EXT_W        8
`define LOW_LSB      0
`define LOW_MSB      15
`define HIGH_LSB     16
`define HIGH_MSB     31
`define EXT_LSB      32
`define EXT_MSB      39

// Multiplier and product
`define PROD_W       32

// Shift amounts
`define SHAMT_W      6
`define PRESHIFT_ONE 1
`define PRESHIFT_HALF 16

// Pipeline depth
`define PIPE_STAGES  3

`endif

/* File: rtl/dspu_pkg.sv */
`include "dspu_defs.svh"

package dspu_pkg;

	typedef enum logic [4:0]
	{
		OP_NOP, OP_LOAD, OP_STORE, OP_MOVE, OP_CLR,
		OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_NEG, OP_ABS,
		OP_INC, OP_DEC,
		OP_MAC_ADD, OP_MAC_SUB, OP_MUL,
		OP_SHL, OP_SHR_ARITH, OP_SHR_LOGIC
	} op_e;

	typedef enum logic [1:0]
	{
		PART_WHOLE, PART_LOW, PART_HIGH, PART_EXT
	} part_e;

	typedef enum logic [1:0]
	{
		PRESHIFT_NONE, PRESHIFT_BY_ONE, PRESHIFT_BY_HALF
	} preshift_e;

	typedef enum logic [1:0]
	{
		SHIFT_LEFT, SHIFT_RIGHT_ARITH, SHIFT_RIGHT_LOGIC
	} shift_mode_e;

	typedef struct packed
	{
		logic                   valid;
		op_e                    op;
		logic [`SEL_W-1:0]      dst;
		part_e                  dst_part;
		logic [`SEL_W-1:0]      src_a;
		part_e                  src_a_part;
		logic [`SEL_W-1:0]      src_b;
		part_e                  src_b_part;
		preshift_e              preshift;
		logic [`SHAMT_W-1:0]    shamt;
		logic [`HALF_W-1:0]     load_data;
	} instr_s;

	typedef struct packed
	{
		logic                   valid;
		logic [`SEL_W-1:0]      dst;
		part_e                  part;
		logic [`REG_W-1:0]      value;
	} wb_s;

	typedef struct packed
	{
		logic                   zero;
		logic                   negative;
		logic                   overflow;
	} flags_s;

endpackage

/* File: rtl/multiply_accumulator.sv */
`include "dspu_defs.svh"

module multiply_accumulator
	import dspu_pkg::*;
(
	// Operands
	input  wire logic [`HALF_W-1:0]  mul_a,
	input  wire logic [`HALF_W-1:0]  mul_b,
	input  wire logic [`REG_W-1:0]   addend,
	// Control
	input  wire dspu_pkg::preshift_e preshift,
	input  wire logic                subtract,
	// Result
	output logic      [`REG_W-1:0]   result
);

	logic signed [`PROD_W-1:0] product;
	logic        [`REG_W-1:0]  product_ext;
	logic        [`REG_W-1:0]  addend_pre_shifter;

	always_comb
	begin
		product = $signed(mul_a) * $signed(mul_b);                              // RULE_11
		product_ext = {{(`REG_W-`PROD_W){product[`PROD_W-1]}}, product};        // RULE_11
		unique case (preshift)
			PRESHIFT_BY_ONE:  addend_pre_shifter = $signed(addend) >>> `PRESHIFT_ONE;  // RULE_06
			PRESHIFT_BY_HALF: addend_pre_shifter = $signed(addend) >>> `PRESHIFT_HALF; // RULE_06
			default:          addend_pre_shifter = addend;
		endcase
		if (subtract)
			result = addend_pre_shifter - product_ext;                          // RULE_05
		else
			result = addend_pre_shifter + product_ext;                          // RULE_05
	end

endmodule

/* File: verif/data_memory_model.sv */
module data_memory_model
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Store path
	input  wire logic        store_valid,
	input  wire logic [15:0] store_data,
	// Last word and count of stores
	output logic      [15:0] word_ff,
	output logic      [7:0]  count_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] nxt_word;
	logic [7:0]  nxt_count;
	always_comb
	begin
		nxt_word  = word_ff;
		nxt_count = count_ff;
		if (rst)
		begin
			nxt_word  = 16'h0000;
			nxt_count = 8'h00;
		end
		else if (store_valid)
		begin
			nxt_word  = store_data;
			nxt_count = count_ff + 8'h01;
		end
	end
	always_ff @(posedge mclk)
	begin
		word_ff  <= nxt_word;
		count_ff <= nxt_count;
	end
endmodule

/* File: verif/dsp_operation_unit_bench.sv */
module dsp_operation_unit_bench import dspu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [39:0] V1 = 40'h7f_8000_0001;
	localparam logic [39:0] V3 = 40'h80_8000_0000;
	logic        mclk;
	logic        rst;
	instr_s      instr;
	wb_s         retire;
	logic        store_valid;
	logic [15:0] store_data;
	flags_s      flags;
	logic [15:0] mem_word;
	logic [7:0]  mem_count;
	int          fail_count;
	int          cmp_count;
	////////////////////////////////////////
	dsp_operation_unit u_dsp_operation_unit (.mclk(mclk), .rst(rst), .instr(instr),
		.retire(retire), .store_valid(store_valid), .store_data(store_data), .flags(flags));
	data_memory_model u_data_memory_model (.mclk(mclk), .rst(rst), .store_valid(store_valid),
		.store_data(store_data), .word_ff(mem_word), .count_ff(mem_count));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	////////////////////////////////////////
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic instr_s mk(op_e op, logic [2:0] d, part_e dp, logic [2:0] a, part_e ap,
		logic [2:0] b, preshift_e pr, logic [5:0] sh, logic [15:0] ld);
		mk = '{1'b1, op, d, dp, a, ap, b, PART_WHOLE, pr, sh, ld};
	endfunction
	function automatic instr_s op2(op_e op, logic [2:0] d, logic [2:0] a, logic [2:0] b,
		preshift_e pr, logic [5:0] sh);
		op2 = mk(op, d, PART_WHOLE, a, PART_WHOLE, b, pr, sh, 16'h0000);
	endfunction
	task automatic send(input instr_s i);
		@(posedge mclk);
		instr <= i;
	endtask
	// Idle the sequencer, then stand where the answer is visible
	task automatic settle();
		@(posedge mclk);
		instr <= '0;
		@(posedge mclk);
		#1;
	endtask
	task automatic run(input instr_s i, input logic [39:0] e, input logic full);
		send(i);
		settle();
		check(retire.valid, 1'b1);
		if (full)
			check(retire.value, e);
	endtask
	task automatic load(input logic [2:0] d, input part_e dp, input logic [15:0] x);
		run(mk(OP_LOAD, d, dp, 3'h0, PART_WHOLE, 3'h0, PRESHIFT_NONE, 6'h00, x), '0, 1'b0);
	endtask
	task automatic put(input logic [2:0] a, input part_e ap, input logic [15:0] e);
		send(mk(OP_STORE, 3'h0, PART_WHOLE, a, ap, 3'h0, PRESHIFT_NONE, 6'h00, 16'h0000));
		settle();
		check({store_valid, retire.valid}, 2'b10);
		check(store_data, e);
	endtask
	////////////////////////////////////////
	task automatic t_parts();
		load(3'h1, PART_HIGH, 16'h8000);
		load(3'h1, PART_LOW, 16'h0001);
		load(3'h1, PART_EXT, 16'h007f);
		load(3'h3, PART_HIGH, 16'h8000);
		load(3'h3, PART_EXT, 16'h0080);
		load(3'h5, PART_HIGH, 16'h0003);
		run(op2(OP_MOVE, 3'h2, 3'h1, 3'h0, PRESHIFT_NONE, 6'h00), V1, 1'b1);
		put(3'h1, PART_LOW, 16'h0001);
		put(3'h1, PART_HIGH, 16'h8000);
		put(3'h1, PART_EXT, 16'h007f);
		put(3'h3, PART_EXT, 16'hff80);
		put(3'h2, PART_WHOLE, 16'h0001);
		@(posedge mclk);
		#1;
		check({mem_count, mem_word}, {8'h05, 16'h0001});
	endtask
	task automatic t_shift();
		logic [5:0] sh [4] = '{6'h00, 6'h01, 6'h04, 6'h27};
		foreach (sh[k])
		begin
			run(op2(OP_SHL, 3'h4, 3'h3, 3'h0, PRESHIFT_NONE, sh[k]), V3 << sh[k], 1'b1);
			run(op2(OP_SHR_ARITH, 3'h4, 3'h3, 3'h0, PRESHIFT_NONE, sh[k]),
				$signed(V3) >>> sh[k], 1'b1);
			run(op2(OP_SHR_LOGIC, 3'h4, 3'h3, 3'h0, PRESHIFT_NONE, sh[k]),
				V3 >> sh[k], 1'b1);
		end
	endtask
	task automatic t_mac();
		logic signed [39:0] p;
		logic signed [39:0] ad [3];
		p  = -40'sd98304;
		ad = '{$signed(V3), $signed(V3) >>> 1, $signed(V3) >>> 16};
		for (int k = 0; k < 3; k++)
		begin
			run(op2(OP_MAC_ADD, 3'h6, 3'h3, 3'h5, preshift_e'(k), 6'h00), ad[k] + p, 1'b1);
			run(op2(OP_MAC_SUB, 3'h6, 3'h3, 3'h5, preshift_e'(k), 6'h00), ad[k] - p, 1'b1);
		end
		run(op2(OP_MUL, 3'h6, 3'h3, 3'h5, PRESHIFT_NONE, 6'h00), p, 1'b1);
	endtask
	// Dependent pair issued back to back, answers on consecutive cycles
	task automatic t_alu();
		send(op2(OP_ADD, 3'h7, 3'h1, 3'h3, PRESHIFT_NONE, 6'h00));
		send(op2(OP_SUB, 3'h6, 3'h7, 3'h1, PRESHIFT_NONE, 6'h00));
		@(posedge mclk);
		instr <= '0;
		#1;
		check(retire.value, V1 + V3);
		@(posedge mclk);
		#1;
		check({retire.valid, retire.dst}, 4'he);
		check(retire.value, V3);
		check(flags, 3'b010);
		run(op2(OP_NOT, 3'h6, 3'h1, 3'h0, PRESHIFT_NONE, 6'h00), ~V1, 1'b1);
	endtask
	// Remaining arithmetic and logic codes, with the flags left by ADD and CLR
	task automatic t_logic();
		run(op2(OP_AND, 3'h4, 3'h1, 3'h3, PRESHIFT_NONE, 6'h00), V1 & V3, 1'b1);
		run(op2(OP_OR, 3'h4, 3'h1, 3'h3, PRESHIFT_NONE, 6'h00), V1 | V3, 1'b1);
		run(op2(OP_XOR, 3'h4, 3'h1, 3'h3, PRESHIFT_NONE, 6'h00), V1 ^ V3, 1'b1);
		run(op2(OP_NEG, 3'h4, 3'h1, 3'h0, PRESHIFT_NONE, 6'h00), -V1, 1'b1);
		run(op2(OP_ABS, 3'h4, 3'h3, 3'h0, PRESHIFT_NONE, 6'h00), -V3, 1'b1);
		run(op2(OP_INC, 3'h4, 3'h1, 3'h0, PRESHIFT_NONE, 6'h00), V1 + 40'h1, 1'b1);
		run(op2(OP_DEC, 3'h4, 3'h3, 3'h0, PRESHIFT_NONE, 6'h00), V3 - 40'h1, 1'b1);
		run(op2(OP_ADD, 3'h4, 3'h1, 3'h1, PRESHIFT_NONE, 6'h00), V1 + V1, 1'b1);
		check(flags, 3'b011);
		run(op2(OP_CLR, 3'h4, 3'h1, 3'h0, PRESHIFT_NONE, 6'h00), 40'h0, 1'b1);
		check(flags, 3'b100);
	endtask
	// Reset in mid-run clears the outputs and general register 1
	task automatic t_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check({retire.valid, store_valid, flags, store_data, mem_count}, '0);
		run(op2(OP_MOVE, 3'h0, 3'h1, 3'h0, PRESHIFT_NONE, 6'h00), 40'h0, 1'b1);
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (3000) @(posedge mclk);
		fail_count++;
		close_out();
	end
	initial
	begin
		fail_count = 0;
		cmp_count  = 0;
		rst        = 1'b1;
		instr      = '0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check({retire.valid, store_valid, flags, store_data}, '0);
		t_parts();
		t_shift();
		t_mac();
		t_alu();
		t_logic();
		t_reset();
		close_out();
	end
endmodule

/* File: verif/dsp_operation_unit_properties.sv */
`include "dspu_defs.svh"

module dsp_operation_unit_checker import dspu_pkg::*;
(
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  rst,
	// Watched ports
	input wire dspu_pkg::instr_s      instr,
	input wire dspu_pkg::wb_s         retire,
	input wire logic                  store_valid,
	input wire logic [`HALF_W-1:0]    store_data,
	input wire dspu_pkg::flags_s      flags
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [39:0] ALL1 = '1;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	chk_store_issue: assert property (instr.valid && instr.op == OP_STORE
		|-> ##2 store_valid && !retire.valid) else $error("store not answered");
	chk_store_cause: assert property (store_valid
		|-> $past(instr.valid, 2) && $past(instr.op, 2) == OP_STORE) else $error("stray store");
	chk_idle_quiet: assert property (!instr.valid
		|-> ##2 !retire.valid && !store_valid && $stable(flags)) else $error("idle acted");
	chk_flags_hold: assert property (instr.valid && instr.op inside {OP_LOAD, OP_STORE}
		|-> ##2 $stable(flags)) else $error("flags moved");
	chk_retire_dest: assert property (retire.valid
		|-> retire.dst == $past(instr.dst, 2) && retire.part == $past(instr.dst_part, 2))
		else $error("wrong destination");
	chk_retire_cause: assert property (retire.valid |-> $past(instr.valid, 2)
		&& !($past(instr.op, 2) inside {OP_NOP, OP_STORE})) else $error("stray retire");
	chk_shl_fill: assert property (instr.valid && instr.op == OP_SHL
		|-> ##2 (retire.value & ~(ALL1 << $past(instr.shamt, 2))) == '0)
		else $error("left shift fill");
	chk_shr_zero: assert property (instr.valid && instr.op == OP_SHR_LOGIC
		|-> ##2 (retire.value & ~(ALL1 >> $past(instr.shamt, 2))) == '0)
		else $error("logical fill");
	chk_shr_sign: assert property (instr.valid && instr.op == OP_SHR_ARITH
		|-> ##2 (retire.value & ~(ALL1 >> $past(instr.shamt, 2)))
		== (retire.value[39] ? ~(ALL1 >> $past(instr.shamt, 2)) : '0)) else $error("sign fill");
	chk_mul_sign: assert property (instr.valid && instr.op == OP_MUL
		|-> ##2 retire.value[39:31] inside {9'h000, 9'h1ff}) else $error("product sign");
	cov_back2back: cover property (retire.valid ##1 retire.valid);
	cov_store: cover property (store_valid);
	cov_mac_half: cover property (instr.valid && instr.preshift == PRESHIFT_BY_HALF);
endmodule

bind dsp_operation_unit dsp_operation_unit_checker u_chk (.mclk(mclk), .rst(rst),
	.instr(instr), .retire(retire), .store_valid(store_valid),
	.store_data(store_data), .flags(flags));
